// >>> pscc_pkg.sv
package pscc_pkg;
    // ==========================================
    // register map (byte addresses on apb)
    // ==========================================
    localparam logic [7:0] ADDR_EXT_CONFIG  = 8'h00;
    localparam logic [7:0] ADDR_DELAY_VALUE = 8'h04;
    localparam logic [7:0] ADDR_STAGE_CTRL  = 8'h08;
    localparam logic [7:0] ADDR_INPUT_A     = 8'h0c;
    localparam logic [7:0] ADDR_INPUT_B     = 8'h10;
    localparam logic [7:0] ADDR_STATUS      = 8'h14;
    localparam logic [7:0] RESET_BYTE       = 8'h00;

    // ==========================================
    // extended_config fields
    // ==========================================
    localparam int EXT_DLY_HI   = 7;
    localparam int EXT_DLY_LO   = 5;
    localparam int EXT_FLANK_HI = 4;
    localparam int EXT_SENSE_A  = 3;
    localparam int EXT_SENSE_B  = 2;
    localparam int EXT_SOURCE_A = 1;
    localparam int EXT_SOURCE_B = 0;

    // ==========================================
    // stage_control fields
    // ==========================================
    localparam int CTL_DIV_HI   = 7;
    localparam int CTL_DIV_LO   = 6;
    localparam int CTL_FLANK_LO = 5;
    localparam int CTL_DIRECT_B = 4;
    localparam int CTL_DIRECT_A = 3;
    localparam int CTL_CHAIN    = 2;
    localparam int CTL_FINISH   = 1;
    localparam int CTL_RUN      = 0;

    // input control: source low bit 6, sense low bit 5
    localparam int INP_SOURCE_LO = 6;
    localparam int INP_SENSE_LO  = 5;

    // ==========================================
    // encodings
    // ==========================================
    localparam logic [2:0] DLY_NONE      = 3'h0;
    localparam logic [2:0] DLY_BLANK_EOC = 3'h1;
    localparam logic [2:0] DLY_BLANK_SA  = 3'h2;
    localparam logic [2:0] DLY_BLANK_SB  = 3'h3;
    localparam logic [1:0] SENSE_FALL    = 2'h0;
    localparam logic [1:0] SENSE_RISE    = 2'h1;
    localparam logic [1:0] SENSE_TOGGLE  = 2'h2;
    localparam logic [1:0] SRC_SHARED    = 2'h0;
    localparam logic [1:0] SRC_CMP1      = 2'h1;
    localparam logic [1:0] SRC_ALT       = 2'h2;
    localparam logic [1:0] SRC_CMP2      = 2'h3;
    localparam logic [5:0] DIV_MAX_1     = 6'h00;
    localparam logic [5:0] DIV_MAX_4     = 6'h03;
    localparam logic [5:0] DIV_MAX_16    = 6'h0f;
    localparam logic [5:0] DIV_MAX_64    = 6'h3f;

    typedef enum logic [1:0] {
        PSCC_IDLE     = 2'b00,
        PSCC_RUN      = 2'b01,
        PSCC_FINISH   = 2'b11
    } pscc_state_t;
endpackage

// >>> pscc_input_sel.sv
`timescale 1ns/10ps
module pscc_input_sel
    import pscc_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    input  wire logic [1:0] source_in,
    input  wire logic [1:0] sense_in,
    input  wire logic       blank_in,
    input  wire logic       shared_in,
    input  wire logic       cmp1_in,
    input  wire logic       alt_in,
    input  wire logic       cmp2_in,
    output logic            event_out,
    output logic            level_out
);
    logic raw_sel;
    logic sel_prev;
    logic next_event;
    logic next_level;

    // ==========================================
    // source selection
    // ==========================================
    assign raw_sel = (source_in == SRC_SHARED) ? shared_in :
                     (source_in == SRC_CMP1)   ? cmp1_in :
                     (source_in == SRC_ALT)    ? alt_in : cmp2_in;

    // ==========================================
    // edge and level classification
    // ==========================================
    assign next_event = blank_in ? 1'b0 :
                        (sense_in == SENSE_FALL)   ? ( sel_prev & ~raw_sel) :
                        (sense_in == SENSE_RISE)   ? (~sel_prev &  raw_sel) :
                        (sense_in == SENSE_TOGGLE) ? ( sel_prev ^  raw_sel) :
                        1'b0; // reserved code never fires
    assign next_level = blank_in ? 1'b0 :
                        (sense_in == SENSE_FALL) ? ~raw_sel :
                        (sense_in == SENSE_RISE) ?  raw_sel :
                        1'b0;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sel_prev  <= 1'b0;
            event_out <= 1'b0;
            level_out <= 1'b0;
        end else begin
            sel_prev  <= raw_sel;
            event_out <= next_event;
            level_out <= next_level;
        end
    end
endmodule

// >>> pscc_top.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module pscc_top
    import pscc_pkg::*;
#(
    parameter int DELAY_W = 8
) (
    input  wire logic               clock_in,
    input  wire logic               srst_in,
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [7:0]         paddr_in,
    input  wire logic [31:0]        pwdata_in,
    output logic      [31:0]        prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out,
    input  wire logic               shared_input_pin_in,
    input  wire logic               alternate_input_pin_in,
    input  wire logic               cmp1_in,
    input  wire logic               cmp2_in,
    input  wire logic               prev_run_in,
    input  wire logic               end_of_cycle_in,
    input  wire logic               match_sa_in,
    input  wire logic               match_sb_in,
    input  wire logic               one_ramp_in,
    input  wire logic               sync_req_in,
    output logic                    tick_out,
    output logic                    run_out,
    output logic                    blank_out,
    output logic                    event_a_out,
    output logic                    event_b_out,
    output logic                    direct_fault_a_out,
    output logic                    direct_fault_b_out,
    output logic [1:0]              flank_sel_out,
    output logic                    flank_on_time_out,
    output logic                    converter_sync_signal_out,
    output logic [1:0]              chain_state_out
);
    import pscc_pkg::*;

    // ==========================================
    // registers and apb decode
    // ==========================================
    logic [7:0] extended_config;
    logic [7:0] delay_count_value;
    logic [7:0] stage_control;
    logic [7:0] input_a_ctrl;
    logic [7:0] input_b_ctrl;
    logic       wr_acc;
    logic       hit;
    logic [7:0] rd_byte;
    logic       run_clear_req;

    assign wr_acc = psel_in & penable_in & pwrite_in;
    assign hit = (paddr_in == ADDR_EXT_CONFIG) | (paddr_in == ADDR_DELAY_VALUE) |
                 (paddr_in == ADDR_STAGE_CTRL) | (paddr_in == ADDR_INPUT_A) |
                 (paddr_in == ADDR_INPUT_B) | (paddr_in == ADDR_STATUS);
    // delay value is write only and reads back as zero
    assign rd_byte = (paddr_in == ADDR_EXT_CONFIG) ? extended_config :
                     (paddr_in == ADDR_STAGE_CTRL) ? stage_control :
                     (paddr_in == ADDR_INPUT_A)    ? input_a_ctrl :
                     (paddr_in == ADDR_INPUT_B)    ? input_b_ctrl :
                     (paddr_in == ADDR_STATUS)     ? {6'h00, chain_state_out} :
                     RESET_BYTE;
    assign run_clear_req = wr_acc & (paddr_in == ADDR_STAGE_CTRL) & ~pwdata_in[CTL_RUN];

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            extended_config   <= RESET_BYTE;
            delay_count_value <= RESET_BYTE;
            stage_control     <= RESET_BYTE;
            input_a_ctrl      <= RESET_BYTE;
            input_b_ctrl      <= RESET_BYTE;
        end else if (wr_acc) begin
            if (paddr_in == ADDR_EXT_CONFIG) begin
                extended_config <= pwdata_in[7:0];
            end else if (paddr_in == ADDR_DELAY_VALUE) begin
                delay_count_value <= pwdata_in[7:0];
            end else if (paddr_in == ADDR_STAGE_CTRL) begin
                stage_control <= pwdata_in[7:0];
            end else if (paddr_in == ADDR_INPUT_A) begin
                input_a_ctrl <= pwdata_in[7:0];
            end else if (paddr_in == ADDR_INPUT_B) begin
                input_b_ctrl <= pwdata_in[7:0];
            end
        end
    end

    // single wait-free access phase
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~hit;
            prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // ==========================================
    // run control
    // ==========================================
    logic        start_req;
    logic        chained;
    logic        finish_en;
    pscc_state_t state;
    pscc_state_t next_state;

    // run wins over chain; chain follows the previous stage
    assign start_req = stage_control[CTL_RUN] | (stage_control[CTL_CHAIN] & prev_run_in);
    assign chained   = stage_control[CTL_CHAIN];
    assign finish_en = stage_control[CTL_FINISH] & ~chained;

    always_comb begin
        next_state = state;
        case (state)
            PSCC_IDLE: begin
                if (start_req) begin
                    next_state = PSCC_RUN;
                end
            end
            PSCC_RUN: begin
                if (!start_req) begin
                    next_state = finish_en ? PSCC_FINISH : PSCC_IDLE;
                end
            end
            PSCC_FINISH: begin
                if (start_req) begin
                    next_state = PSCC_RUN;
                end else if (end_of_cycle_in) begin
                    next_state = PSCC_IDLE;
                end
            end
            default: begin
                next_state = PSCC_IDLE;
            end
        endcase
    end

    logic running;
    logic start_pulse;
    assign running     = (next_state != PSCC_IDLE);
    assign start_pulse = (state == PSCC_IDLE) & running;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state           <= PSCC_IDLE;
            run_out         <= 1'b0;
            chain_state_out <= 2'h0;
        end else begin
            state           <= next_state;
            run_out         <= running;
            chain_state_out <= next_state;
        end
    end

    // ==========================================
    // prescaler
    // ==========================================
    logic [5:0] div_cnt;
    logic [5:0] div_max;
    logic       div_tick;
    logic [1:0] div_sel;

    assign div_sel  = stage_control[CTL_DIV_HI:CTL_DIV_LO];
    assign div_max  = (div_sel == 2'h0) ? DIV_MAX_1 :
                      (div_sel == 2'h1) ? DIV_MAX_4 :
                      (div_sel == 2'h2) ? DIV_MAX_16 : DIV_MAX_64;
    assign div_tick = running & (div_cnt >= div_max);

    always_ff @(posedge clock_in) begin
        if (srst_in | start_pulse | ~running) begin
            div_cnt  <= 6'h00;
            tick_out <= 1'b0;
        end else begin
            div_cnt  <= div_tick ? 6'h00 : div_cnt + 6'h01;
            tick_out <= div_tick;
        end
    end

    // ==========================================
    // blanking and sync delay
    // ==========================================
    logic [2:0]         dly_sel;
    logic               blank_start;
    logic [DELAY_W-1:0] blank_cnt;
    logic [DELAY_W-1:0] sync_cnt;
    logic               sync_busy;
    logic [3:0]         sub_cnt;
    logic [3:0]         sub_max;
    logic               sub_tick;

    assign dly_sel     = extended_config[EXT_DLY_HI:EXT_DLY_LO];
    assign blank_start = ((dly_sel == DLY_BLANK_EOC) & end_of_cycle_in) |
                         ((dly_sel == DLY_BLANK_SA) & match_sa_in) |
                         ((dly_sel == DLY_BLANK_SB) & match_sb_in);
    assign sub_max  = (4'h1 << dly_sel[1:0]) - 4'h1;
    assign sub_tick = tick_out & (sub_cnt >= sub_max);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            blank_cnt <= '0;
            blank_out <= 1'b0;
        end else if (blank_start && delay_count_value != RESET_BYTE) begin
            blank_cnt <= delay_count_value;
            blank_out <= 1'b1;
        end else if (dly_sel == DLY_NONE || dly_sel[2]) begin
            blank_out <= 1'b0;
        end else if (blank_out && tick_out) begin
            blank_cnt <= blank_cnt - 1'b1;
            blank_out <= (blank_cnt > 1);
        end
    end

    // delayed sync is only in modes 4..7; in modes 0..3 the request always passes through registered
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sync_cnt                  <= '0;
            sync_busy                 <= 1'b0;
            sub_cnt                   <= 4'h0;
            converter_sync_signal_out <= 1'b0;
        end else if (!dly_sel[2]) begin
            sync_busy                 <= 1'b0;
            sub_cnt                   <= 4'h0;
            converter_sync_signal_out <= sync_req_in;
        end else if (sync_req_in && !sync_busy) begin
            sync_cnt                  <= delay_count_value;
            sync_busy                 <= (delay_count_value != RESET_BYTE);
            sub_cnt                   <= 4'h0;
            converter_sync_signal_out <= (delay_count_value == RESET_BYTE);
        end else if (sync_busy && tick_out) begin
            sub_cnt <= sub_tick ? 4'h0 : sub_cnt + 4'h1;
            if (sub_tick) begin
                sync_cnt                  <= sync_cnt - 1'b1;
                sync_busy                 <= (sync_cnt > 1);
                converter_sync_signal_out <= (sync_cnt == 1);
            end else begin
                converter_sync_signal_out <= 1'b0;
            end
        end else begin
            converter_sync_signal_out <= 1'b0;
        end
    end

    // ==========================================
    // input parts a and b
    // ==========================================
    logic [1:0] src [2];
    logic [1:0] sns [2];
    logic       ev  [2];
    logic       lv  [2];
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            cmp_s1 <= 2'h0;
            cmp_s2 <= 2'h0;
        end else begin
            pin_s1 <= {alternate_input_pin_in, shared_input_pin_in};
            pin_s2 <= pin_s1;
            cmp_s1 <= {cmp2_in, cmp1_in};
            cmp_s2 <= cmp_s1;
        end
    end

    assign src[0] = {extended_config[EXT_SOURCE_A], input_a_ctrl[INP_SOURCE_LO]};
    assign src[1] = {extended_config[EXT_SOURCE_B], input_b_ctrl[INP_SOURCE_LO]};
    assign sns[0] = {extended_config[EXT_SENSE_A], input_a_ctrl[INP_SENSE_LO]};
    assign sns[1] = {extended_config[EXT_SENSE_B], input_b_ctrl[INP_SENSE_LO]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_part
            pscc_input_sel u_sel (
                .clock_in    (clock_in),
                .srst_in     (srst_in),
                .source_in   (src[gi]),
                .sense_in    (sns[gi]),
                .blank_in    (blank_out),
                .shared_in   (pin_s2[0]),
                .cmp1_in     (cmp_s2[0]),
                .alt_in      (pin_s2[1]),
                .cmp2_in     (cmp_s2[1]),
                .event_out   (ev[gi]),
                .level_out   (lv[gi])
            );
        end
    endgenerate

    // ==========================================
    // outputs to waveform side
    // ==========================================
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            event_a_out        <= 1'b0;
            event_b_out        <= 1'b0;
            direct_fault_a_out <= 1'b0;
            direct_fault_b_out <= 1'b0;
            flank_sel_out      <= 2'h0;
            flank_on_time_out  <= 1'b0;
        end else begin
            event_a_out        <= ev[0];
            event_b_out        <= ev[1];
            // raw level, no prescaler wait; feeds out 0 and second out a
            direct_fault_a_out <= stage_control[CTL_DIRECT_A] & lv[0];
            direct_fault_b_out <= stage_control[CTL_DIRECT_B] & lv[1];
            flank_sel_out      <= {extended_config[EXT_FLANK_HI], stage_control[CTL_FLANK_LO]};
            flank_on_time_out  <= one_ramp_in | ~extended_config[EXT_FLANK_HI];
        end
    end

    // ==========================================
    // checks
    // ==========================================
    a_run_priority: assert property (@(posedge clock_in) disable iff (srst_in)
        stage_control[CTL_RUN] |=> run_out) else $error("run bit did not start");
    a_chain_start: assert property (@(posedge clock_in) disable iff (srst_in)
        (stage_control[CTL_CHAIN] && prev_run_in) |=> run_out) else $error("chain start missed");
    a_finish_hold: assert property (@(posedge clock_in) disable iff (srst_in)
        (state == PSCC_FINISH && !end_of_cycle_in && !start_req) |=> run_out)
        else $error("halted before cycle end");
    a_slave_nofin: assert property (@(posedge clock_in) disable iff (srst_in)
        (state == PSCC_RUN && chained && !start_req) |=> state == PSCC_IDLE)
        else $error("slave used finish cycle");
    a_div_range: assert property (@(posedge clock_in) disable iff (srst_in)
        div_cnt <= div_max || $changed(div_sel)) else $error("prescaler overran");
    a_no_blank_zero: assert property (@(posedge clock_in) disable iff (srst_in)
        (dly_sel == DLY_NONE || dly_sel[2]) |=> !blank_out) else $error("blank outside blank modes");
    a_blank_masks: assert property (@(posedge clock_in) disable iff (srst_in)
        blank_out |=> !ev[0] && !ev[1]) else $error("event during blanking");
    a_reserved_quiet: assert property (@(posedge clock_in) disable iff (srst_in)
        (sns[0] == 2'h3 && $past(sns[0]) == 2'h3) |-> !ev[0]) else $error("reserved sense fired");
    a_flank_map: assert property (@(posedge clock_in) disable iff (srst_in)
        ##1 flank_sel_out == $past({extended_config[EXT_FLANK_HI], stage_control[CTL_FLANK_LO]}))
        else $error("flank select wrong");
    a_direct_off: assert property (@(posedge clock_in) disable iff (srst_in)
        !stage_control[CTL_DIRECT_A] |=> !direct_fault_a_out) else $error("direct fault a leaked");

    c_start: cover property (@(posedge clock_in) disable iff (srst_in) start_pulse);
    c_finish: cover property (@(posedge clock_in) disable iff (srst_in) state == PSCC_FINISH ##1 state == PSCC_IDLE);
    c_blank: cover property (@(posedge clock_in) disable iff (srst_in) blank_out ##1 !blank_out);
    c_sync: cover property (@(posedge clock_in) disable iff (srst_in) sync_busy ##1 converter_sync_signal_out);
endmodule

// >>> pscc_pins_model.sv
`timescale 1ns/10ps
// ==========================================
// far side: fault pins and comparator outputs
// ==========================================
// level bits: 0 shared pin, 1 first comparator, 2 alternate pin, 3 second comparator
module pscc_pins_model (
    input  wire logic       clock_in,
    input  wire logic [3:0] cmd_in,
    output logic      [3:0] level_out
);
    initial level_out = 4'h0;
    // pins are asynchronous to the block, so only levels are modelled here
    always @(posedge clock_in) begin
        level_out <= cmd_in;
    end
endmodule

// >>> pscc_top_tb.sv
`timescale 1ns/10ps
module pscc_top_tb;
    import pscc_pkg::*;
    logic        clock_in = 1'b0;
    logic        srst_in  = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prev_run = 1'b0, eoc = 1'b0;
    logic        match_sa = 1'b0, sync_req = 1'b0, one_ramp = 1'b0, blank_out, fot, sync_out;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0, rnd, prdata_out;
    logic        pready_out, pslverr_out, tick_out, run_out, ev_a, ev_b, df_a, df_b;
    logic [1:0]  flank_sel_out, chain_state_out;
    logic [3:0]  pin_cmd = 4'h0, pins;
    logic [32:0] exp_q[$];
    int          n_fail = 0, checked = 0, cycles = 0, hits, d;

    always #10 clock_in = ~clock_in;

    pscc_pins_model pscc_pins_model_inst (.clock_in(clock_in), .cmd_in(pin_cmd), .level_out(pins));

    pscc_top pscc_top_inst (
        .clock_in(clock_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .shared_input_pin_in(pins[0]),
        .alternate_input_pin_in(pins[2]), .cmp1_in(pins[1]), .cmp2_in(pins[3]),
        .prev_run_in(prev_run), .end_of_cycle_in(eoc), .match_sa_in(match_sa), .match_sb_in(1'b0),
        .one_ramp_in(one_ramp), .sync_req_in(sync_req), .tick_out(tick_out), .run_out(run_out),
        .blank_out(blank_out), .event_a_out(ev_a), .event_b_out(ev_b), .direct_fault_a_out(df_a),
        .direct_fault_b_out(df_b), .flank_sel_out(flank_sel_out), .flank_on_time_out(fot),
        .converter_sync_signal_out(sync_out), .chain_state_out(chain_state_out));

    // ==========================================
    // bus tasks and checks
    // ==========================================
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic chk(input logic got, input logic want);
        checked++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] %0t output mismatch", $time);
        end
    endtask

    task automatic count_events();
        repeat (8) begin
            @(posedge clock_in);
            hits += ev_a + ev_b;
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // read answers are matched against the oldest note
    always @(posedge clock_in) begin
        if (psel && penable && pready_out === 1'b1 && !pwrite) begin
            checked++;
            if (exp_q.size() == 0 || {pslverr_out, prdata_out} !== exp_q.pop_front()) begin
                n_fail++;
                $display("[ERR] %0t read mismatch at %h", $time, paddr);
            end
        end
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ==========================================
    // scenarios
    // ==========================================
    initial begin
        void'($urandom(32'hc5b44b1a));
        repeat (6) @(posedge clock_in);
        srst_in <= 1'b0;
        rd(ADDR_EXT_CONFIG, 33'h0);
        rd(ADDR_STAGE_CTRL, 33'h0);
        rnd = $urandom;
        apb(1'b1, ADDR_DELAY_VALUE, {24'h0, rnd[7:0]});
        rd(ADDR_DELAY_VALUE, 33'h0);
        rd(8'h18, 33'h1_0000_0000);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, ADDR_EXT_CONFIG, {27'h0, f[1], 4'h0});
            apb(1'b1, ADDR_STAGE_CTRL, {26'h0, f[0], 5'h0});
            rd(ADDR_EXT_CONFIG, {28'h0, f[1], 4'h0});
            chk(flank_sel_out === f[1:0], 1'b1);
            chk(fot === ~f[1], 1'b1);
        end
        one_ramp <= 1'b1;
        repeat (2) @(posedge clock_in);
        chk(fot, 1'b1);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, ADDR_STAGE_CTRL, {24'h0, p[1:0], 6'h1});
            repeat (4) @(posedge clock_in);
            hits = 0;
            repeat (128) begin
                @(posedge clock_in);
                hits += tick_out;
            end
            chk(hits == (128 >> (2 * p)), 1'b1);
        end
        apb(1'b1, ADDR_STAGE_CTRL, 32'h0);
        prev_run <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk(run_out, 1'b0);
        apb(1'b1, ADDR_STAGE_CTRL, 32'h6);
        repeat (2) @(posedge clock_in);
        chk(run_out, 1'b1);
        prev_run <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk(chain_state_out === 2'h0, 1'b1);
        apb(1'b1, ADDR_STAGE_CTRL, 32'h5);
        repeat (2) @(posedge clock_in);
        chk(run_out, 1'b1);
        apb(1'b1, ADDR_STAGE_CTRL, 32'h3);
        apb(1'b1, ADDR_STAGE_CTRL, 32'h2);
        repeat (6) @(posedge clock_in);
        chk(chain_state_out === 2'h3, 1'b1);
        eoc <= 1'b1;
        @(posedge clock_in);
        eoc <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk(chain_state_out === 2'h0, 1'b1);
        // sense code k paired with source code k walks every entry of both tables
        apb(1'b1, ADDR_STAGE_CTRL, 32'h19);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, ADDR_EXT_CONFIG, {28'h0, k[1], k[1], k[1], k[1]});
            apb(1'b1, ADDR_INPUT_A, {25'h0, k[0], k[0], 5'h0});
            apb(1'b1, ADDR_INPUT_B, {25'h0, k[0], k[0], 5'h0});
            rnd = $urandom;
            pin_cmd <= rnd[3:0] & ~(4'h1 << k);
            repeat (8) @(posedge clock_in);
            hits = 0;
            pin_cmd[k] <= 1'b1;
            count_events();
            if (k == 1) begin
                chk(df_a, 1'b1);
                chk(df_b, 1'b1);
            end
            pin_cmd[k] <= 1'b0;
            count_events();
            chk(hits == (k == 3 ? 0 : (k == 2 ? 4 : 2)), 1'b1);
        end
        rnd = $urandom;
        d = {26'h0, rnd[5:0] | 6'h01};
        apb(1'b1, ADDR_DELAY_VALUE, d);
        apb(1'b1, ADDR_EXT_CONFIG, {24'h0, DLY_BLANK_SA, 5'h0});
        match_sa <= 1'b1;
        @(posedge clock_in);
        match_sa <= 1'b0;
        hits = 0;
        repeat (80) begin
            @(posedge clock_in);
            hits += blank_out;
        end
        chk(hits == d, 1'b1);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ADDR_EXT_CONFIG, {24'h0, 1'b1, s[1:0], 5'h0});
            sync_req <= 1'b1;
            @(posedge clock_in);
            sync_req <= 1'b0;
            hits = 0;
            while (sync_out !== 1'b1 && hits < 600) begin
                @(posedge clock_in);
                hits++;
            end
            chk(hits == (d << s) + 1, 1'b1);
        end
        repeat (4) @(posedge clock_in);
        print_verdict();
    end
endmodule
